// [mae_accum.sv]
// Product shifter and saturating accumulator adder
`timescale 1ns/1ps
`default_nettype none
module mae_accum (
  input  wire logic [mae_pkg::PW-1:0] acc_i,     // Accumulator value
  input  wire logic [mae_pkg::PW-1:0] product_reg_i,    // Product register value
  input  wire logic [1:0]             pm_i,      // Product shift mode
  input  wire logic                   ovm_i,     // Saturate on overflow
  output logic      [mae_pkg::PW-1:0] shifted_o, // Shifted product
  output logic      [mae_pkg::PW-1:0] sum_o,     // Sum for accumulator
  output logic                        carry_o,   // Unsigned carry out
  output logic                        ov_o       // Signed overflow
);
  import mae_pkg::*;

  logic [PW:0] raw;

  always_comb begin
    case (pm_i)
      PM_L1:   shifted_o = {product_reg_i[PW-2:0], 1'b0};
      PM_L4:   shifted_o = {product_reg_i[PW-5:0], 4'h0};
      PM_R6:   shifted_o = {{6{product_reg_i[PW-1]}}, product_reg_i[PW-1:6]};
      default: shifted_o = product_reg_i;
    endcase
  end

  assign raw     = {1'b0, acc_i} + {1'b0, shifted_o};
  assign carry_o = raw[PW];
  assign ov_o    = (acc_i[PW-1] == shifted_o[PW-1]) && (raw[PW-1] != acc_i[PW-1]);

  // Saturation direction follows the sign both operands share
  always_comb begin
    if (ovm_i && ov_o) begin
      sum_o = acc_i[PW-1] ? SAT_NEG : SAT_POS;
    end else begin
      sum_o = raw[PW-1:0];
    end
  end

endmodule
`default_nettype wire

// [mae_exec.sv]
// Multiply-accumulate execution datapath with Wishbone register access
//
// Function
// (RULE_01) Each step shifts product by shift mode and adds it into accumulator.
// (RULE_02) Data word loads operand A; data times coefficient goes to product register.
// (RULE_03) Carry set on accumulator addition carry out, cleared otherwise.
// (RULE_04) With load mode zero, operand A loads also write operands B and C.
// (RULE_05) Operand B holds 5 bits, C 4 bits; all three are bus readable/writable.
// (RULE_06) Coefficient address is 16 bits, direct data offset is 7 bits.
// (RULE_07) Start saves prefetch counter, loads coefficient address; end restores it.
// (RULE_08) Prefetch counter steps by one per repeated iteration.
// (RULE_09) After pipeline fill each repeated iteration takes one cycle.
// (RULE_10) Software sets block config bit before coefficients live in RAM block.
// (RULE_11) Direct data address stays fixed across all iterations.
// (RULE_12) Move variant also copies data word to next higher address.
// (RULE_13) Move variant skips copy for mapped registers or external memory.
// (RULE_14) Instruction is two words; single run costs 3, or 4 sharing block.
// (RULE_15) Move variant single run costs 5 when operands and code share block.
// (RULE_16) Repeated run costs n+2 cycles for n iterations, plus wait states.
// (RULE_17) Repeated move variant costs 2n+2 when data shares block with code.
// (RULE_18) Signed overflow sets overflow flag; saturate mode clamps accumulator.
// (RULE_19) Indirect mode updates current aux register and pointer each iteration.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mae_exec (
  input  wire logic                      clk_i,          // 200 MHz core clock
  input  wire logic                      rst_i,          // Synchronous reset
  input  wire logic                      wb_cyc_i,       // Wishbone cycle
  input  wire logic                      wb_stb_i,       // Wishbone strobe
  input  wire logic                      wb_we_i,        // Wishbone write
  input  wire logic [7:0]                wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]                wb_sel_i,       // Wishbone byte lanes
  input  wire logic [31:0]               wb_dat_i,       // Wishbone write data
  output logic      [31:0]               wb_dat_o,       // Wishbone read data
  output logic                           wb_ack_o,       // Wishbone ack
  input  wire logic                      cmd_valid_i,    // Instruction issue
  input  wire mae_pkg::mae_cmd_type      cmd_i,          // Decoded instruction
  output logic                           cmd_ready_o,    // Ready for issue
  output logic                           done_o,         // Last step pulse
  output logic      [1:0]                pc_step_o,      // Program counter advance
  output logic      [mae_pkg::AW-1:0]    pm_addr_o,      // Coefficient address
  input  wire logic [mae_pkg::DW-1:0]    pm_rdata_i,     // Coefficient word
  output logic      [mae_pkg::AW-1:0]    dm_addr_o,      // Data operand address
  input  wire logic [mae_pkg::DW-1:0]    dm_rdata_i,     // Data operand word
  input  wire logic                      dm_onchip_i,    // Address is on-chip RAM
  input  wire logic                      mem_ready_i,    // Operands valid
  output logic                           dm_wr_o,        // Copy write strobe
  output logic      [mae_pkg::AW-1:0]    dm_waddr_o,     // Copy write address
  output logic      [mae_pkg::DW-1:0]    dm_wdata_o,     // Copy write data
  output logic                           ram_block_config_o // Block config bit
);
  import mae_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  mae_state_type     st_r;
  mae_cmd_type       cmd_r;
  logic [CTW-1:0]    ctrl_r;
  logic [PW-1:0]     accumulator_reg;
  logic [PW-1:0]     product_reg;
  logic [DW-1:0]     mult_operand_a;
  logic [T1W-1:0]    mult_operand_b;
  logic [T2W-1:0]    mult_operand_c;
  logic [AW-1:0]     prefetch_counter;
  logic [AW-1:0]     saved_counter_reg;
  logic [RCW-1:0]    rem_r;
  logic [1:0]        extra_r;
  logic [1:0]        stall_r;
  logic              carry_r;
  logic              overflow_flag;
  logic [AW-1:0]     aux_r [NAR];
  logic [ARPW-1:0]   aux_reg_pointer;
  logic [AW-1:0]     daddr_r;
  logic              ack_r;
  logic [31:0]       rdat_r;
  logic              wr_r;
  logic [AW-1:0]     waddr_r;
  logic [DW-1:0]     wdata_r;

  logic              accept;
  logic              step;
  logic              last;
  logic              wr_en;
  logic              rd_en;
  logic [31:0]       rd_mux;
  logic              ar_hit;
  logic [PW-1:0]     shifted;
  logic [PW-1:0]     sum;
  logic              alu_c;
  logic              alu_ov;
  logic signed [PW-1:0] prod;
  logic [AW-1:0]     ar_cur;
  logic [AW-1:0]     ar_upd;
  logic [ARPW-1:0]   arp_n;
  logic [1:0]        pm_mode;
  logic              multi_operand_load_mode;
  logic              overflow_saturate_mode;

  assign pm_mode = ctrl_r[CT_PM +: 2];
  assign multi_operand_load_mode     = ctrl_r[CT_TRM];
  assign overflow_saturate_mode     = ctrl_r[CT_OVM];

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign rd_en  = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_en  = rd_en & wb_we_i;
  assign ar_hit = (wb_adr_i[7:5] == OFF_ARBLK);

  always_comb begin
    rd_mux = 32'h00000000;
    if (ar_hit) begin
      rd_mux[AW-1:0] = aux_r[wb_adr_i[4:2]];
    end else begin
      case (wb_adr_i)
        OFF_CTRL: rd_mux[CTW-1:0] = ctrl_r;
        OFF_STAT: rd_mux[2:0] = {st_r != MAE_IDLE, overflow_flag, carry_r};
        OFF_ACC:  rd_mux = accumulator_reg;
        OFF_PRODUCT_REG: rd_mux = product_reg;
        OFF_OPA:  rd_mux[DW-1:0] = mult_operand_a;
        OFF_OPB:  rd_mux[T1W-1:0] = mult_operand_b; // RULE_05
        OFF_OPC:  rd_mux[T2W-1:0] = mult_operand_c; // RULE_05
        OFF_PFC:  rd_mux[AW-1:0] = prefetch_counter;
        OFF_MCS:  rd_mux[AW-1:0] = saved_counter_reg;
        OFF_ARP:  rd_mux[ARPW-1:0] = aux_reg_pointer;
        default:  rd_mux = 32'h00000000;
      endcase
    end
  end

  // Unmapped offsets still ack, reading zero, so a master never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= rd_en;
      rdat_r <= rd_en ? rd_mux : rdat_r;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && wb_adr_i == OFF_CTRL) begin
      ctrl_r <= CTW'(mrg({27'h0000000, ctrl_r}, wb_dat_i, wb_sel_i));
    end
  end

  assign ram_block_config_o = ctrl_r[CT_CNF]; // RULE_10

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign accept      = (st_r == MAE_IDLE) && cmd_valid_i;
  assign cmd_ready_o = (st_r == MAE_IDLE);
  assign step        = (st_r == MAE_ITER) && (stall_r == extra_r) && mem_ready_i; // RULE_09 RULE_16
  assign last        = step && (rem_r == '0);
  assign done_o      = last;
  assign pc_step_o   = PC_STEP; // RULE_14

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= MAE_IDLE;
    end else begin
      case (st_r)
        MAE_IDLE:  st_r <= accept ? MAE_SETUP : MAE_IDLE;
        MAE_SETUP: st_r <= MAE_FILL;
        MAE_FILL:  st_r <= MAE_ITER;
        MAE_ITER:  st_r <= last ? MAE_IDLE : MAE_ITER;
        default:   st_r <= MAE_IDLE;
      endcase
    end
  end

  // Operand block sharing, and for a move code block sharing, each cost one extra cycle per iteration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r   <= '0;
      rem_r   <= '0;
      extra_r <= 2'h0;
      stall_r <= 2'h0;
    end else if (accept) begin
      cmd_r   <= cmd_i;
      rem_r   <= cmd_i.repeat_prefix;
      extra_r <= {1'b0, cmd_i.ops_same} + {1'b0, cmd_i.is_move & cmd_i.code_same}; // RULE_14 RULE_15 RULE_17
      stall_r <= 2'h0;
    end else if (step) begin
      rem_r   <= rem_r - 1'b1; // RULE_07
      stall_r <= 2'h0;
    end else if (st_r == MAE_ITER && stall_r != extra_r) begin
      stall_r <= stall_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefetch_counter  <= '0;
      saved_counter_reg <= '0;
    end else if (accept) begin
      saved_counter_reg <= prefetch_counter; // RULE_07
      prefetch_counter  <= cmd_i.pma; // RULE_06
    end else if (step) begin
      prefetch_counter  <= last ? saved_counter_reg : prefetch_counter + 1'b1; // RULE_07 RULE_08
    end else if (wr_en && wb_adr_i == OFF_PFC && st_r == MAE_IDLE) begin
      prefetch_counter  <= AW'(mrg({16'h0000, prefetch_counter}, wb_dat_i, wb_sel_i));
    end
  end

  assign pm_addr_o = prefetch_counter;

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  mae_accum u_accum (
    .acc_i     (accumulator_reg),
    .product_reg_i    (product_reg),
    .pm_i      (pm_mode),
    .ovm_i     (overflow_saturate_mode),
    .shifted_o (shifted),
    .sum_o     (sum),
    .carry_o   (alu_c),
    .ov_o      (alu_ov)
  );

  assign prod = $signed(dm_rdata_i) * $signed(pm_rdata_i);

  // A step in the same cycle as a bus write wins the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accumulator_reg <= '0;
      product_reg     <= '0;
    end else if (step) begin
      accumulator_reg <= sum; // RULE_01 RULE_18
      product_reg     <= prod; // RULE_02
    end else if (wr_en && wb_adr_i == OFF_ACC) begin
      accumulator_reg <= mrg(accumulator_reg, wb_dat_i, wb_sel_i);
    end else if (wr_en && wb_adr_i == OFF_PRODUCT_REG) begin
      product_reg     <= mrg(product_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mult_operand_a <= '0;
      mult_operand_b <= '0;
      mult_operand_c <= '0;
    end else if (step) begin
      mult_operand_a <= dm_rdata_i; // RULE_02
      if (!multi_operand_load_mode) begin
        mult_operand_b <= dm_rdata_i[T1W-1:0]; // RULE_04 RULE_05
        mult_operand_c <= dm_rdata_i[T2W-1:0]; // RULE_04 RULE_05
      end
    end else if (wr_en) begin
      if (wb_adr_i == OFF_OPA) begin
        mult_operand_a <= DW'(mrg({16'h0000, mult_operand_a}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFF_OPB && wb_sel_i[0]) begin
        mult_operand_b <= wb_dat_i[T1W-1:0]; // RULE_05
      end
      if (wb_adr_i == OFF_OPC && wb_sel_i[0]) begin
        mult_operand_c <= wb_dat_i[T2W-1:0]; // RULE_05
      end
    end
  end

  // Overflow is sticky: write one to clear, a new overflow wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_r       <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (step) begin
        carry_r <= alu_c; // RULE_03
      end else if (wr_en && wb_adr_i == OFF_STAT && wb_sel_i[0]) begin
        carry_r <= wb_dat_i[ST_C];
      end
      if (step && alu_ov) begin
        overflow_flag <= 1'b1; // RULE_18
      end else if (wr_en && wb_adr_i == OFF_STAT && wb_sel_i[0] && wb_dat_i[ST_OV]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Addressing and data move
  // ****************************************************************
  always_comb begin
    ar_cur = aux_r[aux_reg_pointer];
    case (cmd_r.ind_mode)
      IND_INC:  ar_upd = ar_cur + 1'b1;
      IND_DEC:  ar_upd = ar_cur - 1'b1;
      IND_ADD0: ar_upd = ar_cur + aux_r[0];
      IND_SUB0: ar_upd = ar_cur - aux_r[0];
      default:  ar_upd = ar_cur;
    endcase
    arp_n = cmd_r.arp_load ? cmd_r.arp_new : aux_reg_pointer;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NAR; i++) begin
        aux_r[i] <= '0;
      end
      aux_reg_pointer <= '0;
    end else if (step && cmd_r.indirect) begin
      aux_r[aux_reg_pointer] <= ar_upd; // RULE_19
      aux_reg_pointer        <= arp_n; // RULE_19
    end else if (wr_en && ar_hit) begin
      aux_r[wb_adr_i[4:2]] <= AW'(mrg({16'h0000, aux_r[wb_adr_i[4:2]]}, wb_dat_i, wb_sel_i));
    end else if (wr_en && wb_adr_i == OFF_ARP && wb_sel_i[0]) begin
      aux_reg_pointer <= wb_dat_i[ARPW-1:0];
    end
  end

  // Direct address is latched once, so repeats cannot walk it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      daddr_r <= '0;
    end else if (accept) begin
      daddr_r <= cmd_i.indirect ? aux_r[aux_reg_pointer] : {cmd_i.dp, cmd_i.dma}; // RULE_06 RULE_11
    end else if (step && cmd_r.indirect) begin
      daddr_r <= (arp_n == aux_reg_pointer) ? ar_upd : aux_r[arp_n]; // RULE_19
    end
  end

  assign dm_addr_o = daddr_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r    <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end else begin
      wr_r <= step && cmd_r.is_move && dm_onchip_i; // RULE_12 RULE_13
      if (step) begin
        waddr_r <= daddr_r + 1'b1; // RULE_12
        wdata_r <= dm_rdata_i;
      end
    end
  end

  assign dm_wr_o    = wr_r;
  assign dm_waddr_o = waddr_r;
  assign dm_wdata_o = wdata_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [CCW-1:0] cost_r;
  logic           waited_r;
  logic [CCW-1:0] n_iter;
  logic [CCW-1:0] cost_exp;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cost_r   <= '0;
      waited_r <= 1'b0;
    end else if (accept) begin
      cost_r   <= {{(CCW-1){1'b0}}, 1'b1};
      waited_r <= 1'b0;
    end else if (st_r != MAE_IDLE) begin
      cost_r   <= cost_r + 1'b1;
      waited_r <= waited_r | (st_r == MAE_ITER && stall_r == extra_r && !mem_ready_i);
    end
  end

  assign n_iter   = {{(CCW-RCW-1){1'b0}}, {1'b0, cmd_r.repeat_prefix} + 17'h00001};
  assign cost_exp = CCW'(SETUP_CYC) + n_iter * {{(CCW-2){1'b0}}, 2'h1 + extra_r} - 1'b1;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pfc_load_a: assert property (accept |=> prefetch_counter == $past(cmd_i.pma) // RULE_07
    && saved_counter_reg == $past(prefetch_counter)) else $error("prefetch load wrong");
  pfc_walk_a: assert property (step && rem_r != '0 |=> prefetch_counter == $past(prefetch_counter) + 1'b1) // RULE_08
    else $error("prefetch step wrong");
  pfc_restore_a: assert property (last |=> prefetch_counter == $past(saved_counter_reg) // RULE_07
    && st_r == MAE_IDLE) else $error("prefetch not restored");
  acc_add_a: assert property (step && !alu_ov |=> accumulator_reg == $past(accumulator_reg) + $past(shifted)) // RULE_01
    else $error("accumulate wrong");
  product_reg_mult_a: assert property (step |=> product_reg == $past(prod) && mult_operand_a == $past(dm_rdata_i)) // RULE_02
    else $error("multiply wrong");
  carry_flag_a: assert property (step |=> carry_r == $past(alu_c)) else $error("carry wrong"); // RULE_03
  operand_copy_a: assert property (step && !multi_operand_load_mode |=> mult_operand_c == $past(dm_rdata_i[T2W-1:0]) // RULE_04
    && mult_operand_b == $past(dm_rdata_i[T1W-1:0])) else $error("operand copy wrong");
  move_copy_a: assert property (step && cmd_r.is_move && dm_onchip_i |=> dm_wr_o // RULE_12
    && dm_waddr_o == $past(daddr_r) + 1'b1) else $error("data move wrong");
  move_skip_a: assert property (step && !(cmd_r.is_move && dm_onchip_i) |=> !dm_wr_o) // RULE_13
    else $error("data move not skipped");
  direct_hold_a: assert property (st_r != MAE_IDLE && !cmd_r.indirect |=> $stable(dm_addr_o) || $past(accept)) // RULE_11
    else $error("direct address moved");
  rpt_single_a: assert property (st_r == MAE_ITER && extra_r == 2'h0 && mem_ready_i |-> step) // RULE_09
    else $error("iteration stalled");
  single_cost_a: assert property (last && cmd_r.repeat_prefix == '0 && extra_r == 2'h0 && !waited_r |-> cost_r == 20'h00003) // RULE_14
    else $error("single cost wrong");
  move_cost_a: assert property (last && cmd_r.repeat_prefix == '0 && extra_r == 2'h2 && !waited_r |-> cost_r == 20'h00005) // RULE_15
    else $error("move cost wrong");
  rpt_cost_a: assert property (last && !waited_r |-> cost_r == cost_exp + 1'b1) // RULE_16
    else $error("repeat cost wrong");
  sat_clamp_a: assert property (step && overflow_saturate_mode && alu_ov |=> overflow_flag // RULE_18
    && (accumulator_reg == SAT_POS || accumulator_reg == SAT_NEG)) else $error("saturation wrong");

  single_run_c: cover property (accept ##4 (st_r == MAE_IDLE));
  repeat_run_c: cover property (last && cmd_r.repeat_prefix >= 16'h0002);
  move_write_c: cover property (dm_wr_o);
  saturate_c: cover property (step && overflow_saturate_mode && alu_ov);

endmodule
`default_nettype wire

// [mae_mem_model.sv]
// Program and data memory model facing the execution block
`timescale 1ns/1ps
`default_nettype none
module mae_mem_model (
  input  wire logic        clk_i,       // Core clock
  input  wire logic [15:0] pm_addr_i,   // Coefficient address
  output logic      [15:0] pm_rdata_o,  // Coefficient word
  input  wire logic [15:0] dm_addr_i,   // Data address
  output logic      [15:0] dm_rdata_o,  // Data word
  output logic             mem_ready_o  // Data word valid
);
  logic [15:0] last_addr_r = 16'h0000;
  // A fresh data address costs one wait cycle, as a slow memory would
  always @(posedge clk_i) begin
    last_addr_r <= dm_addr_i;
  end
  assign mem_ready_o = (dm_addr_i == last_addr_r);
  // Table rises by one per address so each step sees a distinct coefficient
  assign pm_rdata_o = pm_addr_i - 16'hfefc;
  // Other addresses read back inverted, never a stale word
  assign dm_rdata_o = (dm_addr_i == 16'h0308) ? 16'h0023 : ~dm_addr_i;
endmodule
`default_nettype wire

// [mae_pkg.sv]
// Constants and carrier types shared by the multiply-accumulate execution block
package mae_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DW      = 16;
  localparam int AW      = 16;
  localparam int PW      = 32;
  localparam int T1W     = 5;
  localparam int T2W     = 4;
  localparam int DMAW    = 7;
  localparam int DPW     = 9;
  localparam int RCW     = 16;
  localparam int CCW     = 20;
  localparam int NAR     = 8;
  localparam int ARPW    = 3;
  localparam int CTW     = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [1:0] PC_STEP   = 2'h2;
  localparam int         SETUP_CYC = 2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_ACC   = 8'h08;
  localparam logic [7:0] OFF_PRODUCT_REG  = 8'h0c;
  localparam logic [7:0] OFF_OPA   = 8'h10;
  localparam logic [7:0] OFF_OPB   = 8'h14;
  localparam logic [7:0] OFF_OPC   = 8'h18;
  localparam logic [7:0] OFF_PFC   = 8'h1c;
  localparam logic [7:0] OFF_MCS   = 8'h20;
  localparam logic [7:0] OFF_ARP   = 8'h24;
  localparam logic [2:0] OFF_ARBLK = 3'h2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CT_PM   = 0;
  localparam int CT_TRM  = 2;
  localparam int CT_OVM  = 3;
  localparam int CT_CNF  = 4;
  localparam int ST_C    = 0;
  localparam int ST_OV   = 1;
  localparam int ST_BUSY = 2;
  localparam logic [CTW-1:0] CTRL_RST = 5'h00;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_L1   = 2'h1;
  localparam logic [1:0] PM_L4   = 2'h2;
  localparam logic [1:0] PM_R6   = 2'h3;
  localparam logic [2:0] IND_KEEP = 3'h0;
  localparam logic [2:0] IND_INC  = 3'h1;
  localparam logic [2:0] IND_DEC  = 3'h2;
  localparam logic [2:0] IND_ADD0 = 3'h3;
  localparam logic [2:0] IND_SUB0 = 3'h4;
  localparam logic [PW-1:0] SAT_POS = 32'h7fffffff;
  localparam logic [PW-1:0] SAT_NEG = 32'h80000000;

  typedef enum logic [1:0] {MAE_IDLE, MAE_SETUP, MAE_FILL, MAE_ITER} mae_state_type;

  typedef struct packed {
    logic            is_move;
    logic            indirect;
    logic [AW-1:0]   pma;
    logic [DMAW-1:0] dma;
    logic [DPW-1:0]  dp;
    logic [2:0]      ind_mode;
    logic            arp_load;
    logic [ARPW-1:0] arp_new;
    logic [RCW-1:0]  repeat_prefix;
    logic            ops_same;
    logic            code_same;
  } mae_cmd_type;

endpackage

// [tb_top.sv]
// Self-checking bench for the multiply-accumulate block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  import mae_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, cmd_valid = 0, rdy;
  logic onchip = 1, dm_wr, ram_block_config_bit, mrdy, done;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, d;
  logic [15:0] pma, dma_a, pmd, dmd, wa, wd, cpa, cpd;
  logic [1:0] pcs;
  mae_cmd_type cmd = '0;
  int miscompares = 0, checks = 0, copies = 0, dones = 0, cyc_n;
  mae_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(rdy), .done_o(done), .pc_step_o(pcs),
    .pm_addr_o(pma), .pm_rdata_i(pmd), .dm_addr_o(dma_a), .dm_rdata_i(dmd),
    .dm_onchip_i(onchip), .mem_ready_i(mrdy), .dm_wr_o(dm_wr), .dm_waddr_o(wa),
    .dm_wdata_o(wd), .ram_block_config_o(ram_block_config_bit));
  mae_mem_model i_mem (.clk_i(clk_i), .pm_addr_i(pma), .pm_rdata_o(pmd), .dm_addr_i(dma_a),
    .dm_rdata_o(dmd), .mem_ready_o(mrdy));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (done === 1'b1) dones++;
    if (dm_wr === 1'b1) begin
      copies++;
      cpa = wa;
      cpd = wd;
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= v;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic run(input logic mv, input logic [15:0] r, input logic os, input logic cs, input logic ind);
    @(posedge clk_i);
    cmd_valid <= 1;
    cmd <= '{mv, ind, 16'hff00, 7'h08, 9'h006, IND_INC, ind, 3'h5, r, os, cs};
    @(posedge clk_i);
    cmd_valid <= 0;
    cyc_n = 0;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk_i);
      if (rdy === 1'b1) break;
      cyc_n++;
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #5000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(1, OFF_CTRL, 32'h10);
    `CHK("cnf", 1'b1, ram_block_config_bit)
    `CHK("pc_step", 2'h2, pcs)
    wb(1, OFF_ACC, 32'h0723ec41);
    wb(1, OFF_PRODUCT_REG, 32'h00458972);
    wb(1, OFF_PFC, 32'h10);
    run(1, 16'h0, 1, 1, 0);
    `CHK("cycles move", 5, cyc_n)
    wb(0, OFF_ACC, 0); `CHK("acc", 32'h076975b3, d)
    wb(0, OFF_PRODUCT_REG, 0); `CHK("product_reg", 32'h8c, d)
    wb(0, OFF_STAT, 0); `CHK("carry", 1'b0, d[ST_C])
    wb(0, OFF_OPA, 0); `CHK("opa", 32'h23, d)
    wb(0, OFF_OPB, 0); `CHK("opb", 32'h03, d)
    wb(0, OFF_OPC, 0); `CHK("opc", 32'h3, d)
    `CHK("copy adr", 16'h0309, cpa)
    `CHK("copy dat", 16'h0023, cpd)
    `CHK("pfc", 16'h0010, pma)
    wb(1, OFF_ACC, 0);
    wb(1, OFF_PRODUCT_REG, 0);
    wb(1, OFF_OPB, 32'h1a);
    wb(1, OFF_CTRL, 32'h14);
    run(0, 16'h2, 0, 0, 0);
    `CHK("cycles rpt", 5, cyc_n)
    wb(0, OFF_ACC, 0); `CHK("acc rpt", 32'h13b, d)
    wb(0, OFF_PRODUCT_REG, 0); `CHK("product_reg rpt", 32'hd2, d)
    wb(0, OFF_OPB, 0); `CHK("opb kept", 32'h1a, d)
    wb(0, OFF_PFC, 0); `CHK("pfc rpt", 32'h10, d)
    wb(1, OFF_ACC, 32'h7fffffff);
    wb(1, OFF_PRODUCT_REG, 32'h1);
    wb(1, OFF_CTRL, 32'h18);
    wb(1, 8'h44, 32'h308);
    wb(1, OFF_ARP, 32'h1);
    run(0, 16'h1, 0, 0, 1);
    `CHK("cycles wait", 5, cyc_n)
    wb(0, OFF_ACC, 0); `CHK("acc sat", 32'h7fffffff, d)
    wb(0, OFF_STAT, 0); `CHK("ov flag", 1'b1, d[ST_OV])
    wb(0, OFF_PRODUCT_REG, 0); `CHK("product_reg ind", 32'hfffffffb, d)
    wb(0, 8'h44, 0); `CHK("ar step", 32'h309, d)
    wb(0, OFF_ARP, 0); `CHK("arp", 32'h5, d)
    onchip <= 0;
    run(1, 16'h2, 0, 1, 0);
    `CHK("cycles shared", 8, cyc_n)
    @(negedge clk_i);
    `CHK("no copy", 1, copies)
    `CHK("done pulses", 4, dones)
    stop_test();
  end
endmodule
`default_nettype wire
